// [common/annp_map.vh]
// How it works
// - Expansion bit 6 always reads one
// - Expansion bit 5 reads one: pages in 8
// - Parallel detection fault latches bit 4 high
// - Bit 3 follows partner next-page ability
// - Expansion bit 2 reads constant one
// - New page latches bit 1 until read
// - Bit 0 follows partner negotiation ability
// - Transmit bit 15 next page, reset zero
// - Bit 13 message or unformatted, reset one
// - Bit 12 acknowledge two: will comply
// - Toggle bit 11 inverts previous, reset zero
// - Code field resets one transmit, zero receive
// - Received page captured into register 8
// - Test mode field bits 15:13 selects test
// - Bit 12 enables manual master/slave value
// - Bit 11 manual master one, slave zero
// - Bit 10 port type, resets zero
// - Bit 9 advertises full duplex, reset one
`ifndef ANNP_MAP_VH
`define ANNP_MAP_VH
`define ANNP_IDX_EXP 5'h06
`define ANNP_IDX_NPTX 5'h07
`define ANNP_IDX_NPRX 5'h08
`define ANNP_IDX_MSC 5'h09
`define ANNP_NPTX_RST 16'h2001
`define ANNP_NPRX_RST 16'h0000
`define ANNP_MSC_RST 16'h0200
`define ANNP_NPTX_WMASK 16'hB7FF
`define ANNP_MSC_WMASK 16'hFF00
`define ANNP_BIT_NP 15
`define ANNP_BIT_TOG 11
`define ANNP_BIT_MSEN 12
`define ANNP_BIT_MSVAL 11
`define ANNP_BIT_PORT 10
`define ANNP_BIT_FD 9
`define ANNP_BIT_HD 8
`define ANNP_TM_HI 15
`define ANNP_TM_LO 13
`define ANNP_TM_MAX 3'h4
`endif

// [hdl/annp_latch_bit.v]
`default_nettype none
// Latched-high status bit, cleared by register read
module annp_latch_bit (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_i,
  // Control
  input wire set_i,
  input wire rd_clr_i,
  // Status
  output reg q_o
);
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      q_o <= 1'b0;
    else if (set_i)
      q_o <= 1'b1;
    else if (rd_clr_i)
      q_o <= 1'b0;
  end
endmodule
`default_nettype wire

// [hdl/annp_sync2.v]
`default_nettype none
// Two-flop level synchroniser
module annp_sync2 #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_i,
  // Data
  input wire [WIDTH-1:0] d_i,
  output reg [WIDTH-1:0] q_o
);
  reg [WIDTH-1:0] meta_r;
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_r <= {WIDTH{1'b0}};
      q_o <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule
`default_nettype wire

// [hdl/annp_regs.v]
`include "annp_map.vh"
`default_nettype none
module annp_regs (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_i,
  // Management register port
  input wire [4:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [15:0] reg_wdata_i,
  output reg [15:0] reg_rdata_o,
  // Negotiation engine status (asynchronous)
  input wire pd_fault_i,
  input wire lp_np_able_i,
  input wire lp_an_able_i,
  input wire page_rx_toggle_i,
  input wire [15:0] rx_page_i,
  // Transmit page handshake
  input wire tx_page_sent_i,
  output reg [15:0] tx_page_o,
  // Master/slave control outputs
  output reg [2:0] test_mode_o,
  output reg manual_ms_en_o,
  output reg manual_master_o,
  output reg multi_port_o,
  output reg adv_1000_fd_o,
  output reg adv_1000_hd_o
);
  ////////////////////////////////////////////////////////////////
  // Input synchronisation
  wire [19:0] sync_q;
  reg rx_tog_d_r;
  reg tx_sent_d_r;
  annp_sync2 #(
    .WIDTH(20)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .d_i({tx_page_sent_i, page_rx_toggle_i, pd_fault_i, lp_np_able_i, rx_page_i}),
    .q_o(sync_q)
  );
  wire [15:0] rx_page_s = sync_q[15:0];
  wire lp_np_s = sync_q[16];
  wire pd_fault_s = sync_q[17];
  wire rx_tog_s = sync_q[18];
  wire tx_sent_s = sync_q[19];
  reg lp_an_m_r;
  reg lp_an_s_r;
  wire page_rx_pulse = rx_tog_s ^ rx_tog_d_r;
  wire tx_sent_pulse = tx_sent_s & ~tx_sent_d_r;
  ////////////////////////////////////////////////////////////////
  // Decode
  wire rd_exp = reg_rd_i && (reg_addr_i == `ANNP_IDX_EXP);
  wire wr_nptx = reg_wr_i && (reg_addr_i == `ANNP_IDX_NPTX);
  wire wr_msc = reg_wr_i && (reg_addr_i == `ANNP_IDX_MSC);
  wire pdf_q;
  wire prx_q;
  annp_latch_bit u_pdf (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .set_i(pd_fault_s),
    .rd_clr_i(rd_exp),
    .q_o(pdf_q)
  );
  annp_latch_bit u_prx (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .set_i(page_rx_pulse),
    .rd_clr_i(rd_exp),
    .q_o(prx_q)
  );
  ////////////////////////////////////////////////////////////////
  // Registers
  reg [15:0] nptx_r;
  reg [15:0] nprx_r;
  reg [15:0] msc_r;
  reg tx_tog_r;
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      nptx_r <= `ANNP_NPTX_RST;
      nprx_r <= `ANNP_NPRX_RST;
      msc_r <= `ANNP_MSC_RST;
      tx_tog_r <= 1'b0;
      rx_tog_d_r <= 1'b0;
      tx_sent_d_r <= 1'b0;
      lp_an_m_r <= 1'b0;
      lp_an_s_r <= 1'b0;
    end
    else
    begin
      rx_tog_d_r <= rx_tog_s;
      tx_sent_d_r <= tx_sent_s;
      lp_an_m_r <= lp_an_able_i;
      lp_an_s_r <= lp_an_m_r;
      if (wr_nptx)
        nptx_r <= reg_wdata_i & `ANNP_NPTX_WMASK;
      if (tx_sent_pulse)
        tx_tog_r <= ~tx_tog_r;
      if (page_rx_pulse)
        nprx_r <= rx_page_s;
      if (wr_msc)
        msc_r <= reg_wdata_i & `ANNP_MSC_WMASK;
    end
  end
  ////////////////////////////////////////////////////////////////
  // Outputs and read data
  wire [15:0] exp_val = {9'h000, 1'b1, 1'b1, pdf_q, lp_np_s, 1'b1, prx_q, lp_an_s_r};
  wire [15:0] nptx_val = {nptx_r[15:12], tx_tog_r, nptx_r[10:0]};
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      reg_rdata_o <= 16'h0000;
      tx_page_o <= `ANNP_NPTX_RST;
      test_mode_o <= 3'h0;
      manual_ms_en_o <= 1'b0;
      manual_master_o <= 1'b0;
      multi_port_o <= 1'b0;
      adv_1000_fd_o <= 1'b1;
      adv_1000_hd_o <= 1'b0;
    end
    else
    begin
      tx_page_o <= nptx_val;
      test_mode_o <= (msc_r[`ANNP_TM_HI:`ANNP_TM_LO] > `ANNP_TM_MAX) ? 3'h0 : msc_r[`ANNP_TM_HI:`ANNP_TM_LO];
      manual_ms_en_o <= msc_r[`ANNP_BIT_MSEN];
      manual_master_o <= msc_r[`ANNP_BIT_MSEN] & msc_r[`ANNP_BIT_MSVAL];
      multi_port_o <= msc_r[`ANNP_BIT_PORT];
      adv_1000_fd_o <= msc_r[`ANNP_BIT_FD];
      adv_1000_hd_o <= msc_r[`ANNP_BIT_HD];
      case (reg_addr_i)
        `ANNP_IDX_EXP: reg_rdata_o <= exp_val;
        `ANNP_IDX_NPTX: reg_rdata_o <= nptx_val;
        `ANNP_IDX_NPRX: reg_rdata_o <= nprx_r;
        `ANNP_IDX_MSC: reg_rdata_o <= msc_r;
        default: reg_rdata_o <= 16'h0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// [verif/annp_regs_asserts.sv]
`default_nettype none
module annp_regs_asserts (
  // Clock, reset, writes
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [15:0] reg_wdata_i,
  // Control outputs
  input wire logic [2:0] test_mode_o,
  input wire logic manual_ms_en_o,
  input wire logic manual_master_o,
  input wire logic multi_port_o,
  input wire logic adv_1000_fd_o
);
  timeunit 1ns / 1ps;
  wire logic w9 = reg_wr_i && reg_addr_i == 5'h09;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  property p_fd; w9 |-> ##2 adv_1000_fd_o == $past(reg_wdata_i[9], 2); endproperty
  a_fd: assert property (p_fd) else $error("fd");
  property p_mp; w9 |-> ##2 multi_port_o == $past(reg_wdata_i[10], 2); endproperty
  a_mp: assert property (p_mp) else $error("mp");
  property p_en; w9 |-> ##2 manual_ms_en_o == $past(reg_wdata_i[12], 2); endproperty
  a_en: assert property (p_en) else $error("en");
  property p_mv; manual_master_o |-> manual_ms_en_o; endproperty
  a_mv: assert property (p_mv) else $error("mv");
  property p_tm; test_mode_o <= 3'h4; endproperty
  a_tm: assert property (p_tm) else $error("tm");
  property p_tw; w9 |-> ##2 test_mode_o == 3'h0 || test_mode_o == $past(reg_wdata_i[15:13], 2); endproperty
  a_tw: assert property (p_tw) else $error("tw");
  property p_rs; $fell(rst_i) |-> adv_1000_fd_o && !multi_port_o; endproperty
  a_rs: assert property (p_rs) else $error("rs");
  property p_rt; $fell(rst_i) |-> test_mode_o == 3'h0 && !manual_master_o; endproperty
  a_rt: assert property (p_rt) else $error("rt");
  c_w9: cover property (w9);
  c_mm: cover property (manual_master_o);
  c_t4: cover property (test_mode_o == 3'h4);
endmodule
`default_nettype wire

// [verif/annp_lp.sv]
`default_nettype none
module annp_lp (
  // Clock
  input wire logic ref_clk_i,
  // Partner status and pages
  output logic pd_fault_i = 1'b0,
  output logic lp_np_able_i = 1'b0,
  output logic lp_an_able_i = 1'b0,
  output logic page_rx_toggle_i = 1'b0,
  output logic [15:0] rx_page_i = 16'h0000,
  output logic tx_page_sent_i = 1'b0
);
  timeunit 1ns / 1ps;
  task automatic st(input logic [2:0] s);
    @(posedge ref_clk_i) {pd_fault_i, lp_np_able_i, lp_an_able_i} <= s;
  endtask
  // Page settles before its toggle
  task automatic send(input logic [15:0] p);
    @(posedge ref_clk_i) rx_page_i <= p;
    repeat (4) @(posedge ref_clk_i);
    page_rx_toggle_i <= ~page_rx_toggle_i;
  endtask
  task automatic sent();
    @(posedge ref_clk_i) tx_page_sent_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    tx_page_sent_i <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [verif/tb.sv]
`default_nettype none
module tb;
  timeunit 1ns / 1ps;
  logic ref_clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [4:0] reg_addr_i = 5'h00;
  logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o, tx_page_o, rx_page_i;
  logic [2:0] test_mode_o;
  logic pd_fault_i, lp_np_able_i, lp_an_able_i, page_rx_toggle_i, tx_page_sent_i;
  logic manual_ms_en_o, manual_master_o, multi_port_o, adv_1000_fd_o, adv_1000_hd_o;
  int n_mismatch = 0, tests_run = 0;
  always #2 ref_clk_i = ~ref_clk_i;
  annp_regs u_dut (.*);
  annp_lp u_lp (.*);
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("Error %0t: got %h want %h", $time, s, e);
    end
  endtask
  // Write, or read and compare with d
  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} <= {w, !w, a, d};
    @(posedge ref_clk_i);
    {reg_wr_i, reg_rd_i} <= 2'b00;
    #1 if (!w) chk(reg_rdata_o, d);
  endtask
  task automatic ms(input logic [15:0] d, input logic [15:0] e);
    acc(1'b1, 5'h09, d);
    @(posedge ref_clk_i);
    #1 chk({test_mode_o, manual_ms_en_o, manual_master_o, multi_port_o, adv_1000_fd_o, adv_1000_hd_o, 8'h00}, e);
  endtask
  task automatic t_rst();
    acc(1'b0, 5'h06, 16'h0064);
    acc(1'b0, 5'h07, 16'h2001);
    acc(1'b0, 5'h08, 16'h0000);
    acc(1'b0, 5'h09, 16'h0200);
    acc(1'b0, 5'h0A, 16'h0000);
  endtask
  task automatic t_lat();
    u_lp.st(3'b100);
    repeat (6) @(posedge ref_clk_i);
    u_lp.st(3'b011);
    u_lp.send(16'hD2A5);
    repeat (6) @(posedge ref_clk_i);
    acc(1'b0, 5'h06, 16'h007F);
    acc(1'b0, 5'h06, 16'h006D);
    acc(1'b0, 5'h08, 16'hD2A5);
  endtask
  task automatic t_tx();
    acc(1'b1, 5'h07, 16'hFFFF);
    acc(1'b0, 5'h07, 16'hB7FF);
    u_lp.sent();
    repeat (6) @(posedge ref_clk_i);
    acc(1'b0, 5'h07, 16'hBFFF);
    chk(tx_page_o, 16'hBFFF);
  endtask
  task automatic t_ms();
    ms(16'h9E00, 16'h9E00);
    ms(16'h6800, 16'h6000);
    ms(16'hA200, 16'h0200);
  endtask
  task automatic final_report();
    if (n_mismatch == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_rst();
    t_lat();
    t_tx();
    t_ms();
    final_report();
  end
  initial
  begin
    #20000;
    n_mismatch++;
    final_report();
  end
endmodule
bind annp_regs annp_regs_asserts u_chk (.*);
`default_nettype wire
